//--- logic/cct_timers.sv
/*
 * Three 16-bit capture/compare/PWM timer units with a combined interrupt
 * per unit. Control and status are plain ports, one slice per timer.
 * Assumes capture inputs and the shared external clock are synchronous.
 */
// Notes on behaviour
// - three independent 16-bit counter units
// - system clock, internal scaled-down clock
// - count on prescaled or external ticks
// - overflow raises interrupt condition
// - per-timer prescaler, shared external clock
// - timer zero: five capture, two compare
// - timers one, two: two capture each
// - edge-selectable capture, may raise interrupt
// - compare match drives pin high/low
// - pwm mode from two compares
// - per-timer interrupt from enabled conditions
// - interrupt holds until all enabled flags cleared
`timescale 1ns/1ns
module cct_timers
  import cct_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  ext_clk_i,
  input  wire logic [CCT_NUM_TMR-1:0] run_i,
  input  wire logic [CCT_NUM_TMR-1:0] use_ext_i,
  input  wire logic [CCT_NUM_TMR-1:0][CCT_PRE_W-1:0] divide_i,
  input  wire logic [CCT_NUM_TMR-1:0] cnt_clear_i,
  input  wire logic [CCT_NUM_TMR-1:0][CCT_MAX_CAP-1:0] cap_pin_i,
  input  wire logic [CCT_NUM_TMR-1:0][CCT_MAX_CAP-1:0][1:0] cap_edge_i,
  input  wire logic [CCT_NUM_TMR-1:0][CCT_NUM_CMP-1:0][CCT_CNT_W-1:0]
                                     cmp_val_i,
  input  wire logic [CCT_NUM_TMR-1:0][CCT_NUM_CMP-1:0] cmp_level_i,
  input  wire cct_out_mode_t [CCT_NUM_TMR-1:0] out_mode_i,
  input  wire logic [CCT_NUM_TMR-1:0][CCT_PEND_W-1:0] int_en_i,
  input  wire logic [CCT_NUM_TMR-1:0][CCT_PEND_W-1:0] pend_clr_i,
  output logic [CCT_NUM_TMR-1:0][CCT_CNT_W-1:0] count_o,
  output logic [CCT_NUM_TMR-1:0][CCT_MAX_CAP-1:0][CCT_CNT_W-1:0]
                                     cap_val_o,
  output logic [CCT_NUM_TMR-1:0][CCT_PEND_W-1:0] pend_o,
  output logic [CCT_NUM_TMR-1:0][CCT_NUM_CMP-1:0] cmp_pin_o,
  output logic [CCT_NUM_TMR-1:0] irq_o
);

  // channels per timer: five on unit zero, two elsewhere
  function automatic int cap_count(input int t);
    return (t == 0) ? CCT_MAX_CAP : 2;
  endfunction : cap_count

  // *****************************************************************
  // one unit per timer
  // *****************************************************************
  genvar t;
  generate
    for (t = 0; t < CCT_NUM_TMR; t++) begin : g_tmr
      cct_tick_if tick_if ();
      logic [CCT_MAX_CAP-1:0] cap_prev;
      logic [CCT_MAX_CAP-1:0] cap_hit;
      logic [CCT_NUM_CMP-1:0] cmp_hit;
      logic                   ovf_hit;
      logic [CCT_PEND_W-1:0]  set_vec;

      // internal scaled clock per timer
      cct_prescaler u_pre (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .use_ext_i (use_ext_i[t]),
        .ext_clk_i (ext_clk_i),
        .divide_i  (divide_i[t]),
        .tick_o    (tick_if.src)
      );

      // ***************************************************************
      // counter
      // ***************************************************************
      assign ovf_hit = run_i[t] & tick_if.tick &
                       (count_o[t] == CCT_CNT_MAX);

      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          count_o[t] <= CCT_CNT_RST;
        end else if (cnt_clear_i[t]) begin
          count_o[t] <= CCT_CNT_RST;
        end else if (run_i[t] && tick_if.tick) begin
          // natural 16-bit wrap from all-ones to zero
          count_o[t] <= count_o[t] + 16'h0001;
        end
      end

      // ***************************************************************
      // capture channels
      // ***************************************************************
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cap_prev <= '0;
        end else begin
          cap_prev <= cap_pin_i[t];
        end
      end

      for (genvar c = 0; c < CCT_MAX_CAP; c++) begin : g_cap
        if (c < cap_count(t)) begin : g_on
          logic rise;
          logic fall;
          assign rise = cap_pin_i[t][c] & ~cap_prev[c];
          assign fall = ~cap_pin_i[t][c] & cap_prev[c];
          // edge select per channel
          assign cap_hit[c] =
            (rise && (cap_edge_i[t][c] == CCT_EDGE_RISE ||
                      cap_edge_i[t][c] == CCT_EDGE_BOTH)) ||
            (fall && (cap_edge_i[t][c] == CCT_EDGE_FALL ||
                      cap_edge_i[t][c] == CCT_EDGE_BOTH));

          always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
              cap_val_o[t][c] <= CCT_CNT_RST;
            end else if (cap_hit[c]) begin
              cap_val_o[t][c] <= count_o[t];
            end
          end
        end else begin : g_off
          // unit without this channel: reads zero, never fires
          assign cap_hit[c] = 1'b0;
          always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
              cap_val_o[t][c] <= CCT_CNT_RST;
            end else begin
              cap_val_o[t][c] <= CCT_CNT_RST;
            end
          end
        end
      end

      // ***************************************************************
      // compare channels and output pins
      // ***************************************************************
      // match only on the tick that lands on the value, so a stalled
      // counter does not refire the event every clock
      for (genvar k = 0; k < CCT_NUM_CMP; k++) begin : g_cmp
        assign cmp_hit[k] = run_i[t] & tick_if.tick &
                            ((count_o[t] + 16'h0001) == cmp_val_i[t][k]);
      end

      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cmp_pin_o[t] <= '0;
        end else begin
          case (out_mode_i[t])
            CCT_OUT_CMP: begin
              // each match forces its pin to the set level
              for (int k = 0; k < CCT_NUM_CMP; k++) begin
                if (cmp_hit[k]) begin
                  cmp_pin_o[t][k] <= cmp_level_i[t][k];
                end
              end
            end
            CCT_OUT_PWM: begin
              // compare 0 starts the pulse, compare 1 ends it on pin 0;
              // a tie lets the end win so a zero-width pulse stays low
              if (cmp_hit[1]) begin
                cmp_pin_o[t][0] <= 1'b0;
              end else if (cmp_hit[0]) begin
                cmp_pin_o[t][0] <= 1'b1;
              end
              cmp_pin_o[t][1] <= 1'b0;
            end
            CCT_OUT_HOLD: begin
              cmp_pin_o[t] <= cmp_pin_o[t];
            end
            default: begin
              cmp_pin_o[t] <= cmp_pin_o[t];
            end
          endcase
        end
      end

      // ***************************************************************
      // pending flags and combined interrupt
      // ***************************************************************
      always_comb begin
        set_vec = '0;
        set_vec[CCT_BIT_CAP0 +: CCT_MAX_CAP] = cap_hit;
        set_vec[CCT_BIT_CMP0 +: CCT_NUM_CMP] = cmp_hit;
        set_vec[CCT_BIT_OVF] = ovf_hit;
      end

      // set beats a clear in the same cycle; bitwise clear
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pend_o[t] <= CCT_PEND_RST;
        end else begin
          pend_o[t] <= (pend_o[t] & ~pend_clr_i[t]) | set_vec;
        end
      end

      // registered level from the flags' next value, held until all enabled flags are cleared
      always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          irq_o[t] <= 1'b0;
        end else begin
          irq_o[t] <= |(((pend_o[t] & ~pend_clr_i[t]) | set_vec)
                        & int_en_i[t]);
        end
      end
    end
  endgenerate

endmodule : cct_timers

//--- logic/cct_pkg.sv
/*
 * Package for the three-unit capture/compare/PWM timer block: unit count,
 * channel counts, widths and reset values shared by cct_timers and cct_prescaler.
 * Assumes a single system clock and an asynchronous active-low reset.
 */
package cct_pkg;

  // *****************************************************************
  // sizes
  // *****************************************************************
  localparam int CCT_NUM_TMR   = 3;
  localparam int CCT_CNT_W     = 16;
  localparam int CCT_MAX_CAP   = 5;
  localparam int CCT_NUM_CMP   = 2;
  localparam int CCT_PRE_W     = 8;
  localparam int CCT_PEND_W    = CCT_MAX_CAP + CCT_NUM_CMP + 1;

  // pending / enable bit positions inside one timer's flag vector
  localparam int CCT_BIT_CAP0  = 0;
  localparam int CCT_BIT_CMP0  = 5;
  localparam int CCT_BIT_OVF   = 7;

  // *****************************************************************
  // reset values and count limit
  // *****************************************************************
  localparam logic [CCT_CNT_W-1:0] CCT_CNT_RST = 16'h0000;
  localparam logic [CCT_CNT_W-1:0] CCT_CNT_MAX = 16'hffff;
  localparam logic [CCT_PRE_W-1:0] CCT_PRE_RST = 8'h00;
  localparam logic [CCT_PEND_W-1:0] CCT_PEND_RST = 8'h00;

  // capture edge select codes
  localparam logic [1:0] CCT_EDGE_NONE = 2'h0;
  localparam logic [1:0] CCT_EDGE_RISE = 2'h1;
  localparam logic [1:0] CCT_EDGE_FALL = 2'h2;
  localparam logic [1:0] CCT_EDGE_BOTH = 2'h3;

  // compare output pin behaviour
  typedef enum logic [2:0] {
    CCT_OUT_HOLD = 3'b001,
    CCT_OUT_CMP  = 3'b010,
    CCT_OUT_PWM  = 3'b100
  } cct_out_mode_t;

endpackage : cct_pkg

//--- logic/cct_tick_if.sv
/*
 * Interface carrying the count tick from the prescaler to a timer unit.
 * Assumes both ends run on the block's single clock.
 */
`timescale 1ns/1ns
interface cct_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface : cct_tick_if

//--- logic/cct_prescaler.sv
/*
 * Tick source for one timer: divided system clock or external clock edge.
 * Assumes the external clock is synchronous to ref_clk_i.
 */
`timescale 1ns/1ns
module cct_prescaler
  import cct_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic                 use_ext_i,
  input  wire logic                 ext_clk_i,
  input  wire logic [CCT_PRE_W-1:0] divide_i,
  cct_tick_if.src                   tick_o
);

  logic [CCT_PRE_W-1:0] div_cnt;
  logic                 ext_prev;

  // *****************************************************************
  // prescale divider
  // *****************************************************************
  // divide of n gives one tick every n+1 clocks
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_cnt <= CCT_PRE_RST;
    end else if (div_cnt >= divide_i) begin
      div_cnt <= CCT_PRE_RST;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_clk_i;
    end
  end

  // counts on external rising edge or on prescaler wrap
  assign tick_o.tick = use_ext_i ? (ext_clk_i & ~ext_prev)
                                 : (div_cnt >= divide_i);

endmodule : cct_prescaler

//--- testbench/cct_far_end.sv
/* Far-end model: shared external count clock and the capture pins.
   Assumes the bench calls its tasks just after a clock edge. */
`timescale 1ns/1ns
module cct_far_end
  import cct_pkg::*;
(
  input  wire logic                                  ref_clk_i,
  output logic                                       ext_clk_o,
  output logic [CCT_NUM_TMR-1:0][CCT_MAX_CAP-1:0] cap_pin_o
);
  // ext clock stands low outside bursts
  initial begin
    ext_clk_o = 1'b0;
    cap_pin_o = '0;
  end
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      #2 ext_clk_o = 1'b1;
      @(posedge ref_clk_i);
      #2 ext_clk_o = 1'b0;
    end
  endtask : ext_pulses
  task automatic set_pin(input int t, input int c, input logic v);
    @(posedge ref_clk_i);
    #2 cap_pin_o[t][c] = v;
  endtask : set_pin
endmodule : cct_far_end

//--- testbench/cct_timers_props.sv
/* Port checker for cct_timers, watching timer 0.
   Assumes one clock domain; bound onto the design below. */
`timescale 1ns/1ns
module cct_timers_props
  import cct_pkg::*;
(
  input wire logic                                   ref_clk_i,
  input wire logic                                   resetn_i,
  input wire logic [CCT_NUM_TMR-1:0]                 run_i,
  input wire logic [CCT_NUM_TMR-1:0]                 use_ext_i,
  input wire logic [CCT_NUM_TMR-1:0][CCT_PRE_W-1:0] divide_i,
  input wire logic [CCT_NUM_TMR-1:0]                 cnt_clear_i,
  input wire logic [CCT_NUM_TMR-1:0][CCT_NUM_CMP-1:0][CCT_CNT_W-1:0]
                                                     cmp_val_i,
  input wire logic [CCT_NUM_TMR-1:0][CCT_NUM_CMP-1:0] cmp_level_i,
  input wire cct_out_mode_t [CCT_NUM_TMR-1:0]        out_mode_i,
  input wire logic [CCT_NUM_TMR-1:0][CCT_PEND_W-1:0] int_en_i,
  input wire logic [CCT_NUM_TMR-1:0][CCT_PEND_W-1:0] pend_clr_i,
  input wire logic [CCT_NUM_TMR-1:0][CCT_CNT_W-1:0] count_o,
  input wire logic [CCT_NUM_TMR-1:0][CCT_PEND_W-1:0] pend_o,
  input wire logic [CCT_NUM_TMR-1:0][CCT_NUM_CMP-1:0] cmp_pin_o,
  input wire logic [CCT_NUM_TMR-1:0]                 irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  a_count_hold: assert property (
    !run_i[0] && !cnt_clear_i[0] |=> $stable(count_o[0]))
    else $error("count moved while stopped");
  a_count_step: assert property (
    !$stable(count_o[0]) && !$past(cnt_clear_i[0])
    |-> count_o[0] == $past(count_o[0]) + 16'h0001)
    else $error("count step not one");
  a_clear_zero: assert property (
    cnt_clear_i[0] |=> count_o[0] == 16'h0000)
    else $error("clear did not zero count");
  a_div_spacing: assert property (
    !$stable(count_o[0]) && run_i[0] && !use_ext_i[0]
    && divide_i[0] == 8'h03 |=> $stable(count_o[0]) [*3])
    else $error("prescaled tick too early");
  a_ovf_flag: assert property (
    $past(count_o[0]) == 16'hffff && count_o[0] == 16'h0000
    && !$past(cnt_clear_i[0]) |-> pend_o[0][CCT_BIT_OVF])
    else $error("overflow flag missing");
  a_irq_combine: assert property (
    irq_o[0] == |(pend_o[0] & $past(int_en_i[0])))
    else $error("irq disagrees with flags");
  a_pend_clear: assert property (
    pend_o[0][CCT_BIT_CMP0] && pend_clr_i[0][CCT_BIT_CMP0]
    && count_o[0] + 16'h0001 != cmp_val_i[0][0]
    |=> !pend_o[0][CCT_BIT_CMP0])
    else $error("compare flag not cleared");
  a_cmp_hit: assert property (
    !$stable(count_o[0]) && !$past(cnt_clear_i[0])
    && count_o[0] == $past(cmp_val_i[0][0])
    && $past(out_mode_i[0]) == CCT_OUT_CMP
    |-> cmp_pin_o[0][0] == $past(cmp_level_i[0][0])
    && pend_o[0][CCT_BIT_CMP0])
    else $error("compare match not seen on pin");
endmodule : cct_timers_props
bind cct_timers cct_timers_props u_props (.ref_clk_i, .resetn_i, .run_i,
  .use_ext_i, .divide_i, .cnt_clear_i, .cmp_val_i, .cmp_level_i,
  .out_mode_i, .int_en_i, .pend_clr_i, .count_o, .pend_o, .cmp_pin_o,
  .irq_o);

//--- testbench/tb_cct_timers.sv
/* Bench for cct_timers: prescale, ext clock, overflow, irq, PWM, capture.
   Assumes cct_far_end drives the ext clock and capture pins. */
`timescale 1ns/1ns
module tb_cct_timers
  import cct_pkg::*;
;
  logic                   ref_clk_i = 1'b0;
  logic                   resetn_i = 1'b0;
  wire logic              ext_clk_i;
  wire logic [2:0][4:0]   cap_pin_i;
  logic [2:0]             run_i, use_ext_i, cnt_clear_i;
  logic [2:0][7:0]        divide_i, int_en_i, pend_clr_i;
  logic [2:0][4:0][1:0]   cap_edge_i;
  logic [2:0][1:0][15:0]  cmp_val_i;
  logic [2:0][1:0]        cmp_level_i, cmp_pin_o;
  cct_out_mode_t [2:0]    out_mode_i;
  logic [2:0][15:0]       count_o;
  logic [2:0][4:0][15:0]  cap_val_o;
  logic [2:0][7:0]        pend_o;
  logic [2:0]             irq_o;
  int                     fail_count, n_tests;

  always #20 ref_clk_i = ~ref_clk_i;
  cct_far_end far (.ref_clk_i, .ext_clk_o(ext_clk_i),
    .cap_pin_o(cap_pin_i));
  cct_timers uut (.ref_clk_i, .resetn_i, .ext_clk_i, .run_i, .use_ext_i,
    .divide_i, .cnt_clear_i, .cap_pin_i, .cap_edge_i, .cmp_val_i,
    .cmp_level_i, .out_mode_i, .int_en_i, .pend_clr_i, .count_o,
    .cap_val_o, .pend_o, .cmp_pin_o, .irq_o);

  task automatic nxt(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask : nxt
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // bounded wait, a little beyond one full wrap at divide zero
  task automatic wait_cnt(input int t, input logic [15:0] v);
    int k;
    k = 0;
    while (count_o[t] !== v && k < 70000) begin
      nxt(1);
      k++;
    end
    chk("count reached", v, count_o[t]);
  endtask : wait_cnt
  task automatic t_count;
    logic [2:0][15:0] c;
    divide_i = {8'h00, 8'h00, 8'h03};
    use_ext_i = 3'b100;
    run_i = 3'b111;
    nxt(4);
    c = count_o;
    fork far.ext_pulses(5); join_none
    nxt(40);
    chk("div by 4", c[0] + 16'h000a, count_o[0]);
    chk("div by 1", c[1] + 16'h0028, count_o[1]);
    chk("ext clock", c[2] + 16'h0005, count_o[2]);
    $display("count test done");
  endtask : t_count
  task automatic t_ovf;
    run_i[0] = 1'b0;
    nxt(1);
    divide_i[0] = 8'h00;
    cmp_val_i[0] = {16'h0020, 16'h0010};
    cmp_level_i[0] = 2'b01;
    // timer one stays in hold: a level of one must never reach its pins
    cmp_level_i[1] = 2'b11;
    out_mode_i[0] = CCT_OUT_CMP;
    int_en_i[0] = 8'ha0;
    cnt_clear_i[0] = 1'b1;
    nxt(1);
    cnt_clear_i[0] = 1'b0;
    run_i[0] = 1'b1;
    wait_cnt(0, 16'hffff);
    nxt(1);
    chk("wrap", 16'h0000, count_o[0]);
    chk("ovf flag", 16'h0001, pend_o[0][7]);
    chk("pin high", 16'h0001, cmp_pin_o[0][0]);
    chk("irq", 16'h0001, irq_o[0]);
    chk("t1 ovf", 16'h0001, pend_o[1][7]);
    chk("t1 masked", 16'h0000, irq_o[1]);
    chk("t1 hold pins", 16'h0000, cmp_pin_o[1]);
    pend_clr_i[0] = 8'h80;
    nxt(1);
    pend_clr_i[0] = 8'h20;
    chk("irq held", 16'h0001, irq_o[0]);
    nxt(1);
    pend_clr_i[0] = 8'h00;
    chk("irq dropped", 16'h0000, irq_o[0]);
    $display("overflow test done");
  endtask : t_ovf
  task automatic t_pwm;
    use_ext_i[2] = 1'b0;
    cmp_val_i[2] = {16'h0020, 16'h0010};
    out_mode_i[2] = CCT_OUT_PWM;
    cnt_clear_i[2] = 1'b1;
    nxt(1);
    cnt_clear_i[2] = 1'b0;
    wait_cnt(2, 16'h0018);
    chk("pwm set", 16'h0001, cmp_pin_o[2][0]);
    chk("pwm pin1", 16'h0000, cmp_pin_o[2][1]);
    wait_cnt(2, 16'h0028);
    chk("pwm reset", 16'h0000, cmp_pin_o[2][0]);
    $display("pwm test done");
  endtask : t_pwm
  task automatic t_cap;
    wait_cnt(0, 16'h1234);
    run_i[0] = 1'b0;
    cap_edge_i[0][0] = CCT_EDGE_RISE;
    cap_edge_i[0][4] = CCT_EDGE_FALL;
    cap_edge_i[1][4] = CCT_EDGE_BOTH;
    pend_clr_i[0] = 8'hff;
    nxt(1);
    pend_clr_i[0] = 8'h00;
    far.set_pin(0, 0, 1'b1);
    far.set_pin(0, 4, 1'b1);
    far.set_pin(1, 4, 1'b1);
    nxt(3);
    chk("cap rise", 16'h1234, cap_val_o[0][0]);
    chk("cap flag", 16'h0001, pend_o[0][0]);
    chk("wrong edge", 16'h0000, pend_o[0][4]);
    chk("absent chan", 16'h0000, cap_val_o[1][4]);
    chk("absent flag", 16'h0000, pend_o[1][4]);
    far.set_pin(0, 4, 1'b0);
    nxt(3);
    chk("cap fall", 16'h1234, cap_val_o[0][4]);
    chk("fall flag", 16'h0001, pend_o[0][4]);
    $display("capture test done");
  endtask : t_cap
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial begin
    {run_i, use_ext_i, cnt_clear_i} = '0;
    {divide_i, int_en_i, pend_clr_i} = '0;
    {cap_edge_i, cmp_val_i, cmp_level_i} = '0;
    foreach (out_mode_i[i]) out_mode_i[i] = CCT_OUT_HOLD;
    fail_count = 0;
    n_tests = 0;
    nxt(4);
    resetn_i = 1'b1;
    nxt(1);
    t_count;
    t_ovf;
    t_pwm;
    t_cap;
    end_of_test;
  end
  // whole run is near 70k cycles; allow 100k
  initial begin
    #4000000;
    fail_count++;
    end_of_test;
  end
endmodule : tb_cct_timers
